// *** design/fanout_cfg.svh ***
// Register map, field positions, reset values and frame lengths of the fan-out configuration bank
`ifndef FANOUT_CFG_SVH
`define FANOUT_CFG_SVH

`define REG_WIDTH           16
`define REG_INDEX_WIDTH     4
`define REG_COUNT           16

`define OUTPUT1_CONFIG_IDX  4'h0
`define OUTPUT8_CONFIG_IDX  4'h7
`define INPUT_CONFIG_IDX    4'hb
`define DEVICE_CONTROL_IDX  4'hf

`define OUT_PHASE_BIT       10
`define OUT_EDGE_HI         9
`define OUT_EDGE_LO         7
`define OUT_OE_HI           4
`define OUT_OE_LO           3
`define OUT_TYPE_HI         2
`define OUT_TYPE_LO         1
`define OUT_TRISTATE_BIT    0

`define IN_DIV_HI           5
`define IN_DIV_LO           4
`define IN_TYPE_HI          3
`define IN_TYPE_LO          2
`define IN_MUX_HI           1
`define IN_MUX_LO           0

`define DEV_RESET_BIT       1
`define DEV_POWER_DOWN_BIT  0

`define OUTPUT_WRITE_MASK   16'h079f
`define INPUT_WRITE_MASK    16'h003f
`define DEVICE_WRITE_MASK   16'h0003
`define REG_RESET_VALUE     16'h0000

`define OTYPE_LVDS          2'h0
`define OTYPE_LVCMOS        2'h1
`define OTYPE_HCSL          2'h3

`define HEADER_BITS         5'h10
`define FRAME_BITS          5'h1f

`endif

// *** design/fanout_pkg.sv ***
// Types shared by the fan-out configuration bank
package fanout_pkg;

	typedef enum logic [2:0] {
		LINK_IDLE   = 3'b001,
		LINK_HEADER = 3'b010,
		LINK_DATA   = 3'b100
	} link_state_t;

	typedef struct packed {
		logic       single_ended_phase_mode;
		logic [2:0] edge_rate_select;
		logic [1:0] output_signal_type;
		logic       output_positive_pin;
		logic       output_negative_pin;
		logic       output_buffer_tristate;
	} output_drive_t;

	typedef struct packed {
		logic [1:0] second_input_divider;
		logic [1:0] input_type_setting;
		logic [1:0] input_mux_select;
	} input_setup_t;

endpackage

// *** design/pin_sync.sv ***
// Three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic pin_in,
	output logic      level_out
);

	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			stage3_reg <= 1'b0;
		end else begin
			stage1_reg <= pin_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// A single-cycle disagreement is treated as a glitch and held off
	always_ff @(posedge core_clk) begin
		if (rst) begin
			level_out <= 1'b0;
		end else if (stage2_reg == stage3_reg) begin
			level_out <= stage3_reg;
		end
	end

endmodule

`default_nettype wire

// *** design/fanout_config_bank.sv ***
// Serial-port configuration register bank and decoded clock-path controls of the fan-out buffer
`timescale 1ns/1ps
`default_nettype none
`include "fanout_cfg.svh"

// Functional notes
// - Registers 0 to 7 each configure one clock output, register 0 the first and 7 the eighth.
// - Bit 10 picks opposite-phase (set) or in-phase (clear) single-ended pins, clear at power up.
// - Bits 9 to 7 pick the output edge rate, 111 is medium, and the field powers up as zero.
// - For single-ended outputs the enable pair 11, 10, 01, 00 turns on both, positive, negative, none.
// - For differential outputs enable 00 turns the pair off and 11 turns it fully on.
// - Bits 2 to 1 pick the output type: 11 HCSL, 01 LVCMOS, 00 LVDS, 10 reserved.
// - Bit 0 set puts the output buffer in tri-state, clear enables it, clear at power up.
// - Register 11 bits 3 to 2 pick the type of both inputs: 11 HCSL, 10 or 01 LVCMOS, 00 LVDS.
// - Register 11 bits 1 to 0 pick select pin, automatic switching, second input or first input.
// - Register 15 bit 1 holds the device in reset while set, clear at power up.
// - Register 15 bit 0 powers the device down while set, clear at power up.
// - Every register is 16 bits wide and is moved as one two-byte word.
// - The low four bits of the register address field select the target register.
module fanout_config_bank (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire logic                     spi_cs_n,
	input  wire logic                     spi_clk,
	input  wire logic                     spi_din,
	output logic                          spi_dout,
	output logic                          spi_dout_oe_n,
	output fanout_pkg::output_drive_t [7:0] output_drive,
	output fanout_pkg::input_setup_t      input_setup,
	output logic                          device_reset_hold,
	output logic                          device_power_down
);

	logic                      cs_active_sync;
	logic                      clk_sync;
	logic                      din_sync;
	logic                      clk_prev_reg;
	logic                      cs_prev_reg;
	logic                      clk_rise;
	logic                      clk_fall;
	logic                      frame_start;
	logic                      frame_end;

	logic [`REG_WIDTH-1:0]     regs [`REG_COUNT];
	fanout_pkg::link_state_t   state_reg;
	logic [4:0]                bit_count_reg;
	logic [`REG_WIDTH-1:0]     shift_in_reg;
	logic [`REG_WIDTH-1:0]     shift_out_reg;
	logic                      read_reg;
	logic [`REG_INDEX_WIDTH-1:0] index_reg;
	logic                      commit;
	logic [`REG_WIDTH-1:0]     commit_data;

	pin_sync u_cs_sync (
		.core_clk  (core_clk),
		.rst       (rst),
		.pin_in    (~spi_cs_n),
		.level_out (cs_active_sync)
	);

	pin_sync u_clk_sync (
		.core_clk  (core_clk),
		.rst       (rst),
		.pin_in    (spi_clk),
		.level_out (clk_sync)
	);

	pin_sync u_din_sync (
		.core_clk  (core_clk),
		.rst       (rst),
		.pin_in    (spi_din),
		.level_out (din_sync)
	);

	// The select pin is inverted before synchronising, so high here means a frame is open
	always_ff @(posedge core_clk) begin
		if (rst) begin
			clk_prev_reg <= 1'b0;
			cs_prev_reg  <= 1'b0;
		end else begin
			clk_prev_reg <= clk_sync;
			cs_prev_reg  <= cs_active_sync;
		end
	end

	assign clk_rise    = cs_active_sync && clk_sync && !clk_prev_reg;
	assign clk_fall    = cs_active_sync && !clk_sync && clk_prev_reg;
	assign frame_start = cs_active_sync && !cs_prev_reg;
	assign frame_end   = !cs_active_sync && cs_prev_reg;

	// Only documented fields hold state; everything else stays at zero for ever
	function automatic logic [`REG_WIDTH-1:0] write_mask(
		input logic [`REG_INDEX_WIDTH-1:0] idx
	);
		logic [`REG_WIDTH-1:0] mask;
		mask = 16'h0000;
		if (idx <= `OUTPUT8_CONFIG_IDX) begin
			mask = `OUTPUT_WRITE_MASK;
		end else if (idx == `INPUT_CONFIG_IDX) begin
			mask = `INPUT_WRITE_MASK;
		end else if (idx == `DEVICE_CONTROL_IDX) begin
			mask = `DEVICE_WRITE_MASK;
		end
		return mask;
	endfunction

	// Frame: read flag, fifteen address bits, then sixteen data bits per register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg     <= fanout_pkg::LINK_IDLE;
			bit_count_reg <= 5'h00;
			shift_in_reg  <= 16'h0000;
			read_reg      <= 1'b0;
			index_reg     <= 4'h0;
		end else if (frame_end || frame_start) begin
			state_reg     <= frame_start ? fanout_pkg::LINK_HEADER : fanout_pkg::LINK_IDLE;
			bit_count_reg <= 5'h00;
			shift_in_reg  <= 16'h0000;
		end else if (clk_rise) begin
			shift_in_reg  <= {shift_in_reg[`REG_WIDTH-2:0], din_sync};
			case (state_reg)
				fanout_pkg::LINK_HEADER: begin
					if (bit_count_reg == 5'h00) begin
						read_reg <= din_sync;
					end
					if (bit_count_reg == `HEADER_BITS - 5'h01) begin
						index_reg     <= {shift_in_reg[2:0], din_sync};
						state_reg     <= fanout_pkg::LINK_DATA;
						bit_count_reg <= 5'h00;
					end else begin
						bit_count_reg <= bit_count_reg + 5'h01;
					end
				end
				fanout_pkg::LINK_DATA: begin
					if (bit_count_reg == `HEADER_BITS - 5'h01) begin
						// Block access: the pointer steps once per completed word
						index_reg     <= index_reg + 4'h1;
						bit_count_reg <= 5'h00;
					end else begin
						bit_count_reg <= bit_count_reg + 5'h01;
					end
				end
				default: begin
					state_reg <= fanout_pkg::LINK_IDLE;
				end
			endcase
		end
	end

	assign commit      = clk_rise && !read_reg && (state_reg == fanout_pkg::LINK_DATA)
	                     && (bit_count_reg == `HEADER_BITS - 5'h01);
	assign commit_data = {shift_in_reg[`REG_WIDTH-2:0], din_sync};

	// Partial words never reach the array; a frame cut short before its first full word leaves it untouched
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				regs[i] <= `REG_RESET_VALUE;
			end
		end else if (commit) begin
			regs[index_reg] <= commit_data & write_mask(index_reg);
		end
	end

	// Reads see only documented fields, so reserved bits and registers come back as zero
	function automatic logic [`REG_WIDTH-1:0] read_word(
		input logic [`REG_INDEX_WIDTH-1:0] idx
	);
		return regs[idx] & write_mask(idx);
	endfunction

	// Read data is loaded when a word slot opens and shifted on falling clock edges
	always_ff @(posedge core_clk) begin
		if (rst) begin
			shift_out_reg <= 16'h0000;
		end else if (clk_rise && read_reg && bit_count_reg == `HEADER_BITS - 5'h01
		             && state_reg == fanout_pkg::LINK_DATA) begin
			shift_out_reg <= read_word(index_reg + 4'h1);
		end else if (clk_rise && state_reg == fanout_pkg::LINK_HEADER
		             && bit_count_reg == `HEADER_BITS - 5'h01) begin
			shift_out_reg <= read_word({shift_in_reg[2:0], din_sync});
		end else if (clk_fall && state_reg == fanout_pkg::LINK_DATA && bit_count_reg != 5'h00) begin
			shift_out_reg <= {shift_out_reg[`REG_WIDTH-2:0], 1'b0};
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			spi_dout      <= 1'b0;
			spi_dout_oe_n <= 1'b1;
		end else begin
			spi_dout      <= shift_out_reg[`REG_WIDTH-1];
			spi_dout_oe_n <= !(read_reg && state_reg == fanout_pkg::LINK_DATA && cs_active_sync);
		end
	end

	// Per-output decode; the enable meaning depends on the signalling type
	function automatic fanout_pkg::output_drive_t decode_output(
		input logic [`REG_WIDTH-1:0] r,
		input logic                  hold
	);
		fanout_pkg::output_drive_t d;
		logic [1:0]                oe;
		logic [1:0]                otype;
		oe                         = r[`OUT_OE_HI:`OUT_OE_LO];
		otype                      = r[`OUT_TYPE_HI:`OUT_TYPE_LO];
		d.single_ended_phase_mode  = r[`OUT_PHASE_BIT];
		d.edge_rate_select         = r[`OUT_EDGE_HI:`OUT_EDGE_LO];
		d.output_signal_type       = otype;
		d.output_buffer_tristate   = r[`OUT_TRISTATE_BIT] || hold;
		if (otype == `OTYPE_LVCMOS) begin
			d.output_positive_pin = oe[1];
			d.output_negative_pin = oe[0];
		end else if (otype == `OTYPE_LVDS || otype == `OTYPE_HCSL) begin
			d.output_positive_pin = (oe == 2'h3);
			d.output_negative_pin = (oe == 2'h3);
		end else begin
			// Reserved type: keep the pins quiet rather than guess
			d.output_positive_pin = 1'b0;
			d.output_negative_pin = 1'b0;
		end
		if (d.output_buffer_tristate) begin
			d.output_positive_pin = 1'b0;
			d.output_negative_pin = 1'b0;
		end
		return d;
	endfunction

	logic hold_now;
	assign hold_now = regs[`DEVICE_CONTROL_IDX][`DEV_RESET_BIT]
	                  || regs[`DEVICE_CONTROL_IDX][`DEV_POWER_DOWN_BIT];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			output_drive <= '0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				output_drive[i] <= decode_output(regs[i], hold_now);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			input_setup       <= '0;
			device_reset_hold <= 1'b0;
			device_power_down <= 1'b0;
		end else begin
			input_setup.second_input_divider <= regs[`INPUT_CONFIG_IDX][`IN_DIV_HI:`IN_DIV_LO];
			input_setup.input_type_setting   <= regs[`INPUT_CONFIG_IDX][`IN_TYPE_HI:`IN_TYPE_LO];
			input_setup.input_mux_select     <= regs[`INPUT_CONFIG_IDX][`IN_MUX_HI:`IN_MUX_LO];
			device_reset_hold <= regs[`DEVICE_CONTROL_IDX][`DEV_RESET_BIT];
			device_power_down <= regs[`DEVICE_CONTROL_IDX][`DEV_POWER_DOWN_BIT];
		end
	end

endmodule

`default_nettype wire

// *** verification/fanout_config_bank_asserts.sv ***
// Port-level assertions for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module fanout_config_bank_asserts (
	input wire logic                       core_clk,
	input wire logic                       rst,
	input wire logic                       spi_cs_n,
	input wire logic                       spi_clk,
	input wire logic                       spi_din,
	input wire logic                       spi_dout,
	input wire logic                       spi_dout_oe_n,
	input wire fanout_pkg::output_drive_t [7:0] output_drive,
	input wire fanout_pkg::input_setup_t   input_setup,
	input wire logic                       device_reset_hold,
	input wire logic                       device_power_down
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic       all_off;
	logic       res_on;
	logic       clk_d;
	logic [4:0] since_rise;
	always_comb begin
		all_off = 1'b1;
		res_on = 1'b0;
		for (int i = 0; i < 8; i++) begin
			all_off &= output_drive[i][0] & ~output_drive[i][1] & ~output_drive[i][2];
			res_on |= output_drive[i][4:3] == 2'h2 && output_drive[i][2:1] != 2'h0;
		end
	end
	// Raw pin is sampled once; synchroniser lag is covered by the bound below
	always_ff @(posedge core_clk) begin
		clk_d <= spi_clk;
		if (rst || (spi_clk && !clk_d))
			since_rise <= 5'h0;
		else if (since_rise != 5'h1f)
			since_rise <= since_rise + 5'h1;
	end
	rst_clear_a: assert property (disable iff (1'b0) rst |=> output_drive == '0
		&& input_setup == '0 && !device_reset_hold && !device_power_down && spi_dout_oe_n)
		else $error("outputs not cleared by reset");
	hold_off_a: assert property (device_reset_hold |-> all_off)
		else $error("outputs active during device reset");
	power_off_a: assert property (device_power_down |-> all_off)
		else $error("outputs active during power down");
	reserved_type_a: assert property (!res_on)
		else $error("reserved output type drives a pin");
	idle_oe_a: assert property (spi_cs_n [*6] |-> spi_dout_oe_n)
		else $error("data out driven while deselected");
	oe_frame_a: assert property ($fell(spi_dout_oe_n) |-> !spi_cs_n)
		else $error("data out enabled outside a frame");
	oe_hold_a: assert property ($fell(spi_dout_oe_n) |-> !spi_dout_oe_n [*8])
		else $error("data out released within a bit");
	late_update_a: assert property ((!$stable(output_drive) || !$stable(input_setup))
		|-> since_rise <= 5'h10)
		else $error("configuration changed without a serial clock");
	cover property ($rose(device_reset_hold));
	cover property ($fell(spi_dout_oe_n));
	cover property (!$stable(input_setup));
endmodule
bind fanout_config_bank fanout_config_bank_asserts fanout_config_bank_asserts_inst (
	.core_clk(core_clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_clk(spi_clk),
	.spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe_n(spi_dout_oe_n),
	.output_drive(output_drive), .input_setup(input_setup),
	.device_reset_hold(device_reset_hold), .device_power_down(device_power_down));
`default_nettype wire

// *** verification/spi_host_model.sv ***
// Behavioural SPI host that frames register transfers
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input  wire logic core_clk,
	output logic      spi_cs_n,
	output logic      spi_clk,
	output logic      spi_din,
	input  wire logic spi_dout
);
	logic [15:0] rd_data;
	event        rd_done;
	initial begin
		spi_cs_n = 1'b1;
		spi_clk = 1'b0;
		spi_din = 1'b0;
	end
	// Read flag, 15 address bits, 16-bit words MSB first; 48 bits repeat the word for a
	// block access, fewer than 32 cut the frame short
	task automatic xfer(input logic rd, input logic [14:0] addr, input logic [15:0] wd,
		input int nbits);
		logic [47:0] sh;
		sh = {rd, addr, wd, wd};
		@(negedge core_clk);
		spi_cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			spi_din = sh[47];
			repeat (10) @(negedge core_clk);
			spi_clk = 1'b1;
			if (i >= 16)
				rd_data = {rd_data[14:0], spi_dout};
			repeat (10) @(negedge core_clk);
			spi_clk = 1'b0;
			sh = sh << 1;
		end
		repeat (10) @(negedge core_clk);
		spi_cs_n = 1'b1;
		// Line no longer carries data once deselected
		spi_din = ~spi_din;
		if (rd && nbits >= 32)
			->rd_done;
		repeat (12) @(negedge core_clk);
	endtask
endmodule
`default_nettype wire

// *** verification/test_fanout_config_bank.sv ***
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_fanout_config_bank;
	logic core_clk, rst, spi_cs_n, spi_clk, spi_din, spi_dout, spi_dout_oe_n;
	fanout_pkg::output_drive_t [7:0] output_drive;
	fanout_pkg::input_setup_t        input_setup;
	logic                            device_reset_hold, device_power_down;
	logic [15:0]                     d, e, exp_q[$];
	int                              num_errors = 0, tests_run = 0, cyc = 0;
	fanout_config_bank fanout_config_bank_inst (.core_clk(core_clk), .rst(rst),
		.spi_cs_n(spi_cs_n), .spi_clk(spi_clk), .spi_din(spi_din), .spi_dout(spi_dout),
		.spi_dout_oe_n(spi_dout_oe_n), .output_drive(output_drive), .input_setup(input_setup),
		.device_reset_hold(device_reset_hold), .device_power_down(device_power_down));
	spi_host_model spi_host_model_inst (.core_clk(core_clk), .spi_cs_n(spi_cs_n),
		.spi_clk(spi_clk), .spi_din(spi_din), .spi_dout(spi_dout));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic wr(input logic [3:0] idx, input logic [15:0] v);
		spi_host_model_inst.xfer(1'b0, {11'($urandom), idx}, v, 32);
	endtask
	task automatic rd(input logic [3:0] idx, input logic [15:0] x);
		exp_q.push_back(x);
		spi_host_model_inst.xfer(1'b1, {11'($urandom), idx}, 16'($urandom), 32);
	endtask
	function automatic logic [15:0] mask(input logic [3:0] i);
		return i < 4'h8 ? 16'h079f : i == 4'hb ? 16'h003f : i == 4'hf ? 16'h0003 : 16'h0000;
	endfunction
	// Differential enables 01 and 10 are left unchecked: their effect is undefined
	function automatic fanout_pkg::output_drive_t dec(input logic [15:0] r);
		logic p, n;
		p = r[2:1] == 2'h1 ? r[4] : r[2:1] != 2'h2 && r[4:3] == 2'h3;
		n = r[2:1] == 2'h1 ? r[3] : p;
		// A tri-stated buffer keeps both pins off whatever the enables say
		return {r[10], r[9:7], r[2:1], p && !r[0], n && !r[0], r[0]};
	endfunction
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(spi_host_model_inst.rd_done) begin
		e = exp_q.pop_front();
		`CHK("read", e, spi_host_model_inst.rd_data)
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 80000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		rst = 1'b1;
		void'($urandom(76));
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge core_clk);
		`CHK("drive_rst", 72'h0, output_drive)
		`CHK("ctrl_rst", 2'h0, {device_reset_hold, device_power_down})
		for (int i = 0; i < 16; i++)
			rd(i[3:0], 16'h0000);
		for (int i = 0; i < 16; i++) begin
			d = 16'($urandom);
			wr(i[3:0], d);
			rd(i[3:0], d & mask(i[3:0]));
		end
		wr(4'hf, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			d = (16'($urandom) & 16'h0781) | {11'h0, i[3:0], 1'b0};
			if (i[1:0] == 2'h1 || i[1:0] == 2'h2 || i[3:2] == 2'h0 || i[3:2] == 2'h3) begin
				wr({1'b0, i[2:0]}, d);
				`CHK("drive", dec(d), output_drive[i[2:0]])
			end
		end
		for (int i = 0; i < 4; i++) begin
			d = {10'($urandom), {3{i[1:0]}}};
			wr(4'hb, d);
			`CHK("input", d[5:0], input_setup)
		end
		for (int i = 3; i >= 0; i--) begin
			wr(4'hf, {14'($urandom), i[1:0]});
			`CHK("ctrl", i[1:0], {device_reset_hold, device_power_down})
			if (i != 0)
				`CHK("forced", 3'h1, output_drive[5][2:0])
		end
		wr(4'h0, 16'h0019);
		spi_host_model_inst.xfer(1'b0, 15'h0000, 16'h0786, 24);
		spi_host_model_inst.xfer(1'b0, 15'h0000, 16'h0786, 31);
		`CHK("partial", dec(16'h0019), output_drive[0])
		rd(4'h0, 16'h0019);
		spi_host_model_inst.xfer(1'b0, 15'h0006, 16'h059a, 48);
		`CHK("block", dec(16'h059a), output_drive[7])
		rd(4'h6, 16'h059a);
		exp_q.push_back(16'h059a);
		spi_host_model_inst.xfer(1'b1, 15'h0006, 16'h0000, 48);
		summarize();
	end
endmodule
`default_nettype wire
